/* File: clk_cfg_pkg.sv */
/*
  Shared constants for the clock ratio select decoder: configuration word
  bit positions, field codes and decoded selection encodings.
  Assumes the configuration word arrives numbered 0 at the most significant
  end, as the loader presents it, and is stable while it is captured.
*/
`default_nettype none
package clk_cfg_pkg;
  localparam int CFG_W = 512;
  // bit positions in msb-first numbering
  localparam int MEM_RANGE_POS = 8;
  localparam int MEM_MULT_POS = 10;
  localparam int MEM_SYNC_POS = 184;
  localparam int MEM_RATE_POS = 232;
  localparam int MEM_SPARE_POS = 234;
  localparam int CORE_CHOICE_POS = 96;
  localparam int LANE_MULT1_POS = 128;
  localparam int LANE_MULT2_POS = 131;
  localparam int LANE_DIV1_POS = 144;
  localparam int LANE_DIV2_POS = 149;
  localparam int PKT_SEL_POS = 160;

  localparam logic [3:0] CHOICE_A_DIV1 = 4'h0;
  localparam logic [3:0] CHOICE_A_DIV2 = 4'h1;
  localparam logic [3:0] CHOICE_B_DIV1 = 4'h4;
  localparam logic [3:0] CHOICE_B_DIV2 = 4'h5;
  localparam logic [4:0] MEM_SYNC_1TO1 = 5'h01;
  localparam logic [4:0] MEM_MULT_RESET = 5'h00;

  typedef enum logic [1:0] {src_a, src_b} pll_src_e;
  // lane multiplier reset: 0 marks "not selected"
  localparam logic [5:0] LANE_MULT_RESET = 6'h00;
endpackage
`default_nettype wire

/* File: cfg_fields_if.sv */
/*
  Carries the raw configuration fields from the capture stage to the
  decoder inside the clock ratio select decoder.
  Assumes a single clock and that fields only change on a capture.
*/
`default_nettype none
interface cfg_fields_if;
  logic valid;
  logic [3:0] core_pll_choice [4];
  logic [1:0] mem_range;
  logic [4:0] memory_pll_multiplier;
  logic mem_sync;
  logic mem_rate;
  logic memory_spare_bit;
  logic [2:0] lane_pll_multiplier [2];
  logic [4:0] lane_bank1_divider;
  logic lane_bank2_divider;
  logic packet_engine_clock_select;
  modport source (output valid, core_pll_choice, mem_range,
    memory_pll_multiplier, mem_sync, mem_rate, memory_spare_bit,
    lane_pll_multiplier, lane_bank1_divider, lane_bank2_divider,
    packet_engine_clock_select);
  modport sink (input valid, core_pll_choice, mem_range,
    memory_pll_multiplier, mem_sync, mem_rate, memory_spare_bit,
    lane_pll_multiplier, lane_bank1_divider, lane_bank2_divider,
    packet_engine_clock_select);
endinterface
`default_nettype wire

/* File: cfg_capture.sv */
/*
  Captures the configuration word fields once, on the first load strobe
  after reset, and holds them for the rest of operation.
  Assumes the loader raises load for one cycle with the word stable.
*/
`default_nettype none
module cfg_capture
  import clk_cfg_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // configuration word
  input wire logic load,
  input wire logic [0:CFG_W-1] reset_configuration_word,
  // captured fields
  cfg_fields_if.source fields
);
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      fields.valid <= 1'b0;
      for (int i = 0; i < 4; i++) fields.core_pll_choice[i] <= CHOICE_A_DIV1;
      fields.mem_range <= 2'h0;
      fields.memory_pll_multiplier <= MEM_MULT_RESET;
      fields.mem_sync <= 1'b0;
      fields.mem_rate <= 1'b0;
      fields.memory_spare_bit <= 1'b0;
      fields.lane_pll_multiplier[0] <= 3'h0;
      fields.lane_pll_multiplier[1] <= 3'h0;
      fields.lane_bank1_divider <= 5'h00;
      fields.lane_bank2_divider <= 1'b0;
      fields.packet_engine_clock_select <= 1'b0;
    end else if (load && !fields.valid) begin
      fields.valid <= 1'b1;
      for (int i = 0; i < 4; i++)
        fields.core_pll_choice[i] <=
          reset_configuration_word[CORE_CHOICE_POS+4*i +: 4];
      fields.mem_range <= reset_configuration_word[MEM_RANGE_POS +: 2];
      fields.memory_pll_multiplier <=
        reset_configuration_word[MEM_MULT_POS +: 5];
      fields.mem_sync <= reset_configuration_word[MEM_SYNC_POS];
      fields.mem_rate <= reset_configuration_word[MEM_RATE_POS];
      fields.memory_spare_bit <= reset_configuration_word[MEM_SPARE_POS];
      fields.lane_pll_multiplier[0] <=
        reset_configuration_word[LANE_MULT1_POS +: 3];
      fields.lane_pll_multiplier[1] <=
        reset_configuration_word[LANE_MULT2_POS +: 3];
      fields.lane_bank1_divider <=
        reset_configuration_word[LANE_DIV1_POS +: 5];
      fields.lane_bank2_divider <= reset_configuration_word[LANE_DIV2_POS];
      fields.packet_engine_clock_select <=
        reset_configuration_word[PKT_SEL_POS];
    end
  end
endmodule
`default_nettype wire

/* File: clock_ratio_select_decoder.sv */
/*
  Clock ratio select decoder: turns captured configuration fields into
  cluster PLL, divider, memory PLL, lane PLL and packet engine selections.
  Assumes the configuration loader strobes load once after reset; all
  outputs are registered and static after the decode cycle.
  A reserved code raises its block's error flag and leaves that block on a
  safe selection, so a corrupt word never reaches a PLL as a ratio.
*/
// Function
// - complexes 0,1: 0000 A/1, 0001 A/2, 0100 B/1; others reserved.
// - complexes 2,3: 0000 A/1, 0100 B/1, 0101 B/2; others reserved.
// - each complex decodes its own field independently.
// - memory PLL reference is external clock async, platform clock sync.
// - sync bit 184 is 0 async, 1 sync; selects memory reference.
// - rate bit 232 follows the mode and must agree with bit 184.
// - async multiplier bits 10-14 equal ratio; 5,6,8,9,10,12,13,16,18,20.
// - sync multiplier only 0_0001, memory rate equals platform clock.
// - lane multipliers: bank1 25,40,50; bank2 also 20,24,30.
// - bank1 divider bit per lane pair, 1 halves; end bits unused.
// - bank2 divider single bit for four lanes, 1 halves.
// - packet engine: 0 platform clock/2, 1 cluster PLL B/2.
// - fields sampled once at power-up and held fixed.
`default_nettype none
module clock_ratio_select_decoder
  import clk_cfg_pkg::*;
#(
  parameter int CORES = 4
) (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // configuration word loader
  input wire logic load,
  input wire logic [0:CFG_W-1] reset_configuration_word,
  // core complex selections: 1 = cluster PLL B, divide: 1 = by 2
  output logic [CORES-1:0] core_src_b,
  output logic [CORES-1:0] core_div2,
  // memory PLL
  output logic mem_ref_platform,
  output logic [4:0] mem_ratio,
  output logic mem_high_range,
  // lane PLLs: multiplier factor, 0 when reserved
  output logic [5:0] lane_bank1_factor,
  output logic [5:0] lane_bank2_factor,
  output logic [2:0] lane_pair_div2,
  output logic lane_bank2_div2,
  // packet engine: 1 = cluster PLL B / 2, 0 = platform / 2
  output logic packet_src_b,
  // status
  output logic decode_done,
  output logic core_cfg_error,
  output logic mem_cfg_error,
  output logic lane_cfg_error
);
  cfg_fields_if fields ();

  cfg_capture capture (
    .clock(clock),
    .rstn(rstn),
    .load(load),
    .reset_configuration_word(reset_configuration_word),
    .fields(fields)
  );

  // returns {ok, src_b, div2} for one complex
  function automatic logic [2:0] core_decode(input logic [3:0] code,
                                             input logic upper);
    logic [2:0] r;
    r = 3'h0;
    case (code)
      CHOICE_A_DIV1: r = 3'h4;
      CHOICE_A_DIV2: r = upper ? 3'h0 : 3'h5;
      CHOICE_B_DIV1: r = 3'h6;
      CHOICE_B_DIV2: r = upper ? 3'h7 : 3'h0;
      default: r = 3'h0;
    endcase
    return r;
  endfunction

  // lane multiplier factor, 0 for reserved
  function automatic logic [5:0] lane_factor(input logic [2:0] code,
                                             input logic bank2);
    logic [5:0] f;
    f = 6'h00;
    case (code)
      3'h2: f = 6'h19;
      3'h3: f = 6'h28;
      3'h4: f = 6'h32;
      3'h1: f = bank2 ? 6'h14 : 6'h00;
      3'h5: f = bank2 ? 6'h18 : 6'h00;
      3'h6: f = bank2 ? 6'h1E : 6'h00;
      default: f = 6'h00;
    endcase
    return f;
  endfunction

  function automatic logic async_ratio_ok(input logic [4:0] code);
    case (code)
      5'h05, 5'h06, 5'h08, 5'h09, 5'h0A, 5'h0C, 5'h0D, 5'h10, 5'h12,
      5'h14: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  logic decoded;
  logic decode_now;
  logic [2:0] cres [CORES];
  logic next_core_err;
  logic next_mem_err;
  logic mem_ok;
  logic rate_mismatch;
  logic range_bad;
  logic [5:0] next_bank1_factor;
  logic [5:0] next_bank2_factor;

  always_comb begin
    next_core_err = 1'b0;
    for (int i = 0; i < CORES; i++) begin
      // each complex uses only its own field; 2 and up use the B table
      cres[i] = core_decode(fields.core_pll_choice[i], i >= 2);
      if (!cres[i][2]) next_core_err = 1'b1;
    end
  end

  always_comb begin
    if (fields.mem_sync)
      mem_ok = fields.memory_pll_multiplier == MEM_SYNC_1TO1;
    else
      mem_ok = async_ratio_ok(fields.memory_pll_multiplier);
    rate_mismatch = fields.mem_rate != fields.mem_sync;
    // only 00 and 01 are legal range codes, so the upper bit must stay clear
    range_bad = fields.mem_range[1];
    next_mem_err = !mem_ok || rate_mismatch || range_bad
      || fields.memory_spare_bit;
  end

  // one decode per bank, shared by the factor outputs and the error flag
  always_comb begin
    next_bank1_factor = lane_factor(fields.lane_pll_multiplier[0], 1'b0);
    next_bank2_factor = lane_factor(fields.lane_pll_multiplier[1], 1'b1);
  end

  // decode exactly once, the cycle after capture; outputs then hold
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) decoded <= 1'b0;
    else if (fields.valid) decoded <= 1'b1;
  end

  // the single decode cycle: fields captured, outputs not yet written
  assign decode_now = fields.valid && !decoded;

  // core complexes; reserved codes fall back to cluster A / 1, a
  // pairing every complex accepts, rather than passing an unknown ratio on
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      core_src_b <= '0;
      core_div2 <= '0;
      core_cfg_error <= 1'b0;
    end else if (decode_now) begin
      for (int i = 0; i < CORES; i++) begin
        core_src_b[i] <= cres[i][1];
        core_div2[i] <= cres[i][0];
      end
      core_cfg_error <= next_core_err;
    end
  end

  // memory PLL; on error the ratio output is held at 0 (PLL not started)
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      mem_ref_platform <= 1'b0;
      mem_ratio <= MEM_MULT_RESET;
      mem_high_range <= 1'b0;
      mem_cfg_error <= 1'b0;
    end else if (decode_now) begin
      mem_ref_platform <= fields.mem_sync;
      mem_ratio <= next_mem_err ? MEM_MULT_RESET
                                : fields.memory_pll_multiplier;
      mem_high_range <= fields.mem_range[0];
      mem_cfg_error <= next_mem_err;
    end
  end

  // lane PLLs and dividers; end bits of bank1 divider are ignored
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      lane_bank1_factor <= LANE_MULT_RESET;
      lane_bank2_factor <= LANE_MULT_RESET;
      lane_pair_div2 <= 3'h0;
      lane_bank2_div2 <= 1'b0;
      lane_cfg_error <= 1'b0;
    end else if (decode_now) begin
      lane_bank1_factor <= next_bank1_factor;
      lane_bank2_factor <= next_bank2_factor;
      lane_pair_div2 <= fields.lane_bank1_divider[3:1];
      lane_bank2_div2 <= fields.lane_bank2_divider;
      lane_cfg_error <= next_bank1_factor == LANE_MULT_RESET ||
        next_bank2_factor == LANE_MULT_RESET;
    end
  end

  // packet engine select
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      packet_src_b <= 1'b0;
    end else if (decode_now) begin
      packet_src_b <= fields.packet_engine_clock_select;
    end
  end

  // completion flag rises in the same cycle as the selections it announces
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      decode_done <= 1'b0;
    end else if (decode_now) begin
      decode_done <= 1'b1;
    end
  end
endmodule
`default_nettype wire

/* File: decoder_sva.sv */
/*
  Port checker for the clock ratio select decoder.
  Assumes one clock domain and rstn asynchronous, active low.
*/
`default_nettype none
module decoder_sva
  import clk_cfg_pkg::*;
#(
  parameter int CORES = 4
) (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // loader
  input wire logic load,
  input wire logic [0:CFG_W-1] reset_configuration_word,
  // selections
  input wire logic [CORES-1:0] core_src_b,
  input wire logic [CORES-1:0] core_div2,
  input wire logic mem_ref_platform,
  input wire logic [4:0] mem_ratio,
  input wire logic mem_high_range,
  input wire logic [5:0] lane_bank1_factor,
  input wire logic [5:0] lane_bank2_factor,
  input wire logic [2:0] lane_pair_div2,
  input wire logic lane_bank2_div2,
  input wire logic packet_src_b,
  // status
  input wire logic decode_done,
  input wire logic core_cfg_error,
  input wire logic mem_cfg_error,
  input wire logic lane_cfg_error
);
  timeunit 1ns;
  timeprecision 1ps;
  logic taken;
  logic first;
  assign first = load && !taken;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) taken <= 1'b0;
    else if (load) taken <= 1'b1;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  done_latency_a: assert property (
    first |-> ##1 !decode_done ##1 decode_done) else $error("late done");
  held_fixed_a: assert property (
    decode_done |=> decode_done && $stable({core_src_b, core_div2,
    mem_ref_platform, mem_ratio, mem_high_range, lane_bank1_factor,
    lane_bank2_factor, lane_pair_div2, lane_bank2_div2, packet_src_b}))
    else $error("selection moved");
  mem_ref_a: assert property (
    first |-> ##3 mem_ref_platform == $past(reset_configuration_word[184], 3))
    else $error("memory reference wrong");
  mem_err_zero_a: assert property (
    mem_cfg_error |-> mem_ratio == 5'h00) else $error("ratio kept on error");
  sync_ratio_a: assert property (
    decode_done && mem_ref_platform && !mem_cfg_error |-> mem_ratio == 5'h01)
    else $error("sync ratio wrong");
  async_ratio_a: assert property (
    decode_done && !mem_ref_platform && !mem_cfg_error |-> mem_ratio inside
    {5'h05, 5'h06, 5'h08, 5'h09, 5'h0A, 5'h0C, 5'h0D, 5'h10, 5'h12, 5'h14})
    else $error("async ratio wrong");
  lane_err_a: assert property (
    decode_done |-> lane_cfg_error == (lane_bank1_factor == 6'h00 ||
    lane_bank2_factor == 6'h00)) else $error("lane error flag wrong");
  pkt_sel_a: assert property (
    first |-> ##3 packet_src_b == $past(reset_configuration_word[160], 3))
    else $error("packet select wrong");
  bank2_div_a: assert property (
    first |-> ##3 lane_bank2_div2 == $past(reset_configuration_word[149], 3))
    else $error("bank2 divider wrong");
  pair_div_a: assert property (
    first |-> ##3 lane_pair_div2 == $past(reset_configuration_word[145+:3], 3))
    else $error("pair divider wrong");
  core0_src_a: assert property (
    first |-> ##3 core_src_b[0] ==
    ($past(reset_configuration_word[96+:4], 3) == 4'h4))
    else $error("complex 0 source wrong");
  core3_div_a: assert property (
    first |-> ##3 core_div2[3] ==
    ($past(reset_configuration_word[108+:4], 3) == 4'h5))
    else $error("complex 3 divide wrong");
endmodule
`default_nettype wire

/* File: cfg_loader.sv */
/*
  Configuration word loader model: one load strobe per go request.
  Assumes go is sampled on the rising edge and lasts one cycle.
*/
`default_nettype none
module cfg_loader
  import clk_cfg_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // bench request
  input wire logic go,
  input wire logic [0:CFG_W-1] word_in,
  // to the decoder
  output logic load,
  output logic [0:CFG_W-1] reset_configuration_word
);
  timeunit 1ns;
  timeprecision 1ps;
  logic g;
  logic [0:CFG_W-1] w;
  initial begin
    load = 1'b0;
    reset_configuration_word = '0;
  end
  always @(posedge clock) begin
    g = go;
    w = word_in;
    #2;
    load = g && rstn;
    // outside the strobe the word wanders so a late capture shows up
    reset_configuration_word = g ? w : ~reset_configuration_word;
  end
endmodule
`default_nettype wire

/* File: tb.sv */
/*
  Self-checking bench for the clock ratio select decoder.
  Assumes the loader model in cfg_loader and the checker in decoder_sva.
*/
`default_nettype none
module tb
  import clk_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CORES = 4;
  logic clock, rstn, go, load, mem_ref_platform, mem_high_range;
  logic lane_bank2_div2, packet_src_b, decode_done;
  logic core_cfg_error, mem_cfg_error, lane_cfg_error;
  logic [0:CFG_W-1] word_in, reset_configuration_word;
  logic [CORES-1:0] core_src_b, core_div2;
  logic [4:0] mem_ratio;
  logic [5:0] lane_bank1_factor, lane_bank2_factor;
  logic [2:0] lane_pair_div2;
  logic [34:0] exp_q[$];
  logic [34:0] got, exp_v;
  logic [31:0] x = 32'h0000002E;
  logic [4:0] atab [10] = '{5'h05, 5'h06, 5'h08, 5'h09, 5'h0A, 5'h0C, 5'h0D,
    5'h10, 5'h12, 5'h14};
  int failures = 0;
  int n_tests = 0;
  cfg_loader i_cfg_loader (.clock(clock), .rstn(rstn), .go(go),
    .word_in(word_in), .load(load),
    .reset_configuration_word(reset_configuration_word));
  clock_ratio_select_decoder #(.CORES(CORES)) i_clock_ratio_select_decoder (
    .clock(clock), .rstn(rstn), .load(load),
    .reset_configuration_word(reset_configuration_word),
    .core_src_b(core_src_b), .core_div2(core_div2),
    .mem_ref_platform(mem_ref_platform), .mem_ratio(mem_ratio),
    .mem_high_range(mem_high_range), .lane_bank1_factor(lane_bank1_factor),
    .lane_bank2_factor(lane_bank2_factor), .lane_pair_div2(lane_pair_div2),
    .lane_bank2_div2(lane_bank2_div2), .packet_src_b(packet_src_b),
    .decode_done(decode_done), .core_cfg_error(core_cfg_error),
    .mem_cfg_error(mem_cfg_error), .lane_cfg_error(lane_cfg_error));
  function automatic logic [31:0] xs();
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction
  function automatic logic [34:0] outs();
    return {core_src_b, core_div2, mem_ref_platform, mem_ratio,
      mem_high_range, lane_bank1_factor, lane_bank2_factor, lane_pair_div2,
      lane_bank2_div2, packet_src_b, core_cfg_error, mem_cfg_error,
      lane_cfg_error};
  endfunction
  function automatic logic [34:0] expect_of(input logic [0:CFG_W-1] w);
    logic [3:0] sb, d2, c;
    logic ce, me, sy;
    logic [4:0] m;
    logic [5:0] f1, f2;
    sb = '0;
    d2 = '0;
    ce = 1'b0;
    for (int i = 0; i < 4; i++) begin
      c = w[96+4*i +: 4];
      if (c == 4'h4) sb[i] = 1'b1;
      else if (c == 4'h1 && i < 2) d2[i] = 1'b1;
      else if (c == 4'h5 && i > 1) {sb[i], d2[i]} = 2'h3;
      else if (c != 4'h0) ce = 1'b1;
    end
    sy = w[184];
    m = w[10 +: 5];
    me = (sy ? m != 5'h01 : !(m inside {atab})) || w[232] != sy || w[234] ||
      w[8];
    case (w[128 +: 3])
      3'h2: f1 = 6'h19;
      3'h3: f1 = 6'h28;
      3'h4: f1 = 6'h32;
      default: f1 = 6'h00;
    endcase
    case (w[131 +: 3])
      3'h1: f2 = 6'h14;
      3'h2: f2 = 6'h19;
      3'h3: f2 = 6'h28;
      3'h4: f2 = 6'h32;
      3'h5: f2 = 6'h18;
      3'h6: f2 = 6'h1E;
      default: f2 = 6'h00;
    endcase
    return {sb, d2, sy, me ? 5'h00 : m, w[9], f1, f2, w[145 +: 3], w[149],
      w[160], ce, me, f1 == 6'h00 || f2 == 6'h00};
  endfunction
  task automatic chk(input string name, input logic [34:0] e, g);
    n_tests++;
    if (e !== g) begin
      $display("BAD %s expected %h seen %h", name, e, g);
      failures++;
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic run(input int k);
    logic [0:CFG_W-1] w;
    logic [31:0] r;
    int i;
    // ratio fields outside this block stay zero, so no frequency limit binds
    w = '0;
    r = xs();
    for (i = 0; i < 4; i++) w[96+4*i +: 4] = 4'(k + i);
    w[8 +: 2] = {k == 5, r[5]};
    w[10 +: 5] = (k % 3 == 0) ? r[4:0] : k[0] ? 5'h01 : atab[k % 10];
    w[184] = k[0];
    w[232] = k[0] ^ (k == 9);
    w[234] = k == 7;
    w[128 +: 6] = r[11:6];
    w[144 +: 6] = r[17:12];
    w[160] = r[18];
    rstn = 1'b0;
    @(posedge clock);
    #2 rstn = 1'b1;
    chk("reset outputs", 35'h0, outs());
    chk("reset done", 35'h0, 35'(decode_done));
    exp_q.push_back(expect_of(w));
    go = 1'b1;
    word_in = w;
    @(posedge clock);
    #2 go = 1'b0;
    for (i = 0; i < 10 && decode_done !== 1'b1; i++) begin
      @(posedge clock);
      #2;
    end
    if (decode_done !== 1'b1) begin
      $display("BAD decode_done expected 1 seen %b", decode_done);
      failures++;
      tally_and_finish();
    end
    // a second strobe after decode must change nothing
    word_in = ~w;
    go = 1'b1;
    @(posedge clock);
    #2 go = 1'b0;
    repeat (4) @(posedge clock);
    #2 chk("held", expect_of(w), outs());
  endtask
  always @(posedge decode_done) begin
    #1;
    got = outs();
    exp_v = exp_q.size() > 0 ? exp_q.pop_front() : 'x;
    chk("core", 35'(exp_v[34:27]), 35'(got[34:27]));
    chk("memory", 35'(exp_v[26:20]), 35'(got[26:20]));
    chk("lane", 35'(exp_v[19:4]), 35'(got[19:4]));
    chk("packet", 35'(exp_v[3]), 35'(got[3]));
    chk("errors", 35'(exp_v[2:0]), 35'(got[2:0]));
  end
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  initial begin
    rstn = 1'b0;
    go = 1'b0;
    word_in = '0;
    repeat (4) @(posedge clock);
    #2;
    for (int k = 0; k < 24; k++) run(k);
    tally_and_finish();
  end
endmodule
bind clock_ratio_select_decoder decoder_sva #(.CORES(CORES)) i_decoder_sva (
  .clock(clock), .rstn(rstn), .load(load),
  .reset_configuration_word(reset_configuration_word),
  .core_src_b(core_src_b), .core_div2(core_div2),
  .mem_ref_platform(mem_ref_platform), .mem_ratio(mem_ratio),
  .mem_high_range(mem_high_range), .lane_bank1_factor(lane_bank1_factor),
  .lane_bank2_factor(lane_bank2_factor), .lane_pair_div2(lane_pair_div2),
  .lane_bank2_div2(lane_bank2_div2), .packet_src_b(packet_src_b),
  .decode_done(decode_done), .core_cfg_error(core_cfg_error),
  .mem_cfg_error(mem_cfg_error), .lane_cfg_error(lane_cfg_error));
`default_nettype wire
